// >>> dv/cpu_core_model.sv
// CPU core model: accepts the forwarded request and runs exception handling.
// Assumes irq_req and irq_vector are registered outputs of the controller.
`timescale 1ns/1ns

module cpu_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic en,
  input wire logic [3:0] lag,
  output logic exc_ack,
  output logic [7:0] exc_vector,
  output logic [7:0] last_vec,
  output int taken
);
  // ----------------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------------
  int wait_n = 0; // Cycles waited before accepting
  int hold = 0; // Gap that lets the flag clear after a handling
  initial begin
    exc_ack = 1'b0;
    exc_vector = 8'h00;
    last_vec = 8'h00;
    taken = 0;
  end
  // Prompt or slow accept; vector toggles when not qualified by the ack
  always @(posedge aclk) begin
    if (hold > 0) begin
      hold <= hold - 1;
      exc_ack <= 1'b0;
      exc_vector <= ~exc_vector;
    end else if (aresetn && en && irq_req && wait_n >= lag) begin
      exc_ack <= 1'b1;
      exc_vector <= irq_vector;
      last_vec <= irq_vector;
      taken <= taken + 1;
      wait_n <= 0;
      hold <= 4;
    end else begin
      exc_ack <= 1'b0;
      exc_vector <= ~exc_vector;
      wait_n <= (aresetn && en && irq_req) ? wait_n + 1 : 0;
    end
  end
endmodule : cpu_core_model

// >>> dv/ext_irq_ctrl_asserts.sv
// Checker of the external request controller, bound to its ports.
// Assumes the single clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ns

module ext_irq_ctrl_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic sw_standby,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  input wire logic [2:0] irq_level,
  input wire logic nmi_req,
  input wire logic standby_wake
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_vec_addr: assert property (irq_vector_addr == {6'h00, irq_vector, 2'h0})
    else $error("vector address is not four times the vector");
  a_idle_vec: assert property (!irq_req |-> irq_vector == 8'h00)
    else $error("vector shown without a request");
  a_nmi_wins: assert property ($rose(nmi_req) |-> ##[0:2] (irq_req && irq_vector == 8'h07))
    else $error("nonmaskable request not forwarded");
  a_nmi_level: assert property (irq_req && irq_vector == 8'h07 |-> irq_level == 3'h7)
    else $error("nonmaskable request not at top level");
  a_wake_pulse: assert property (standby_wake |=> !standby_wake)
    else $error("wake lasts more than one cycle");
  a_wake_cause: assert property (standby_wake |-> sw_standby)
    else $error("wake outside standby");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule : ext_irq_ctrl_asserts

bind ext_irq_ctrl ext_irq_ctrl_asserts chk (.*);

// >>> dv/external_interrupt_flags_tb.sv
// Self-checking bench of the external request controller.
// Assumes the controller, the CPU model and the bound checker.
`timescale 1ns/1ns
`include "ext_irq_defines.svh"

module external_interrupt_flags_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, nmi_pin = 1'b1;
  logic peri_req = 1'b0, sw_standby = 1'b0, cpu_en = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, external_request_pin = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, cpu_lag = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_req, nmi_req, standby_wake, exc_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] irq_vector, exc_vector, last_vec, lfsr = 8'h05;
  logic [15:0] irq_vector_addr;
  logic [2:0] irq_level, p;
  int taken, err_total = 0, checked = 0, n, t0;

  ext_irq_ctrl dut (.*);
  cpu_core_model cpu (.aclk, .aresetn, .irq_req, .irq_vector, .en(cpu_en), .lag(cpu_lag),
    .exc_ack, .exc_vector, .last_vec, .taken);
  always #4 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Pseudo-random pin choice
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask : wt
  task automatic rst();
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
  endtask : rst
  // Register read: holds the address until taken, rready until rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
    bit ga, gr;
    int k;
    gr = 0;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!gr && k < 64) begin
      @(negedge aclk);
      ga = s_axi_arvalid && s_axi_arready;
      gr = s_axi_rvalid;
      q = s_axi_rdata;
      rs = s_axi_rresp;
      k++;
      @(posedge aclk);
      if (ga) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(gr, 1);
  endtask : rd
  // Register write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ga, gw, gb;
    int k;
    gb = 0;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!gb && k < 64) begin
      @(negedge aclk);
      ga = s_axi_awvalid && s_axi_awready;
      gw = s_axi_wvalid && s_axi_wready;
      gb = s_axi_bvalid;
      r = s_axi_bresp;
      k++;
      @(posedge aclk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({gb, r}, 32'h4);
  endtask : wr
  // Flags read and compared with the model bit
  task automatic flag(input logic e);
    rd(`OFF_FLAGS, d, r);
    chk(d[p], e);
  endtask : flag

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    #(8 * 60000);
    err_total++;
    conclude();
  end
  initial begin
    rst();
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, (i == 1) ? 32'h07 : 32'h00);
    end
    rd(8'h1C, d, r);
    chk(r, 32'h2);
    // Every sense code on a random pin, then the clearing sequence
    for (int m = 0; m < 4; m++) begin
      lfsr = nxt(lfsr);
      p = lfsr[2:0];
      wr(`OFF_SENSE, 32'(m) << (2 * p));
      external_request_pin[p] <= 1'b0;
      wt(6);
      flag(m != 2);
      chk(irq_req, 0);
      external_request_pin[p] <= 1'b1;
      wt(6);
      flag(1);
      wr(`OFF_FLAGS, 32'hFF);
      flag(1);
      wr(`OFF_FLAGS, 32'h0);
      flag(0);
    end
    external_request_pin[p] <= 1'b0;
    wt(6);
    wr(`OFF_FLAGS, 32'h0);
    flag(1);
    wr(`OFF_FLAGS, 32'h0);
    flag(0);
    external_request_pin[p] <= 1'b1;
    wt(6);
    // Exception handling clears: falling edge prompt, low level slow
    cpu_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      lfsr = nxt(lfsr);
      p = lfsr[2:0];
      cpu_lag <= 4'(5 * k);
      wr(`OFF_SENSE, 32'(1 - k) << (2 * p));
      wr(`OFF_PIN_EN, 32'h1 << p);
      t0 = taken;
      external_request_pin[p] <= 1'b0;
      n = 0;
      while (taken == t0 && n < 60) begin
        wt(1);
        n++;
      end
      external_request_pin[p] <= 1'b1;
      wt(12);
      chk(last_vec, 32'(16 + p));
      flag(0);
    end
    cpu_en <= 1'b0;
    // Default order, level order, peripheral gate, nonmaskable edge
    wr(`OFF_SENSE, 32'h0410);
    wr(`OFF_PIN_EN, 32'h24);
    peri_req <= 1'b1;
    external_request_pin[2] <= 1'b0;
    external_request_pin[5] <= 1'b0;
    wt(6);
    chk(irq_vector, 32'd18);
    wr(`OFF_PRIO, (32'h3 << 15) | (32'h7 << 24));
    wr(`OFF_CTRL, 32'h20);
    wt(3);
    chk(irq_vector, 32'd21);
    wr(`OFF_CTRL, 32'h121);
    wt(3);
    chk(irq_vector, 32'd33);
    nmi_pin <= 1'b0;
    wt(6);
    chk(nmi_req, 0);
    nmi_pin <= 1'b1;
    wt(6);
    chk({nmi_req, irq_vector}, 32'h107);
    peri_req <= 1'b0;
    external_request_pin <= 8'hFF;
    rst();
    // Standby: disabled pin ignored, enabled pin wakes after settling
    sw_standby <= 1'b1;
    wr(`OFF_SENSE, 32'h0104);
    p = 3'd4;
    external_request_pin[4] <= 1'b0;
    wt(6);
    flag(0);
    external_request_pin[1] <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!standby_wake && n < 1400);
    chk(n >= 1250 && n <= 1256, 1);
    p = 3'd1;
    flag(1);
    sw_standby <= 1'b0;
    // Falling edge selected after reset
    nmi_pin <= 1'b0;
    wt(6);
    chk({nmi_req, irq_vector}, 32'h107);
    conclude();
  end
endmodule : external_interrupt_flags_tb

// >>> rtl/ext_irq_ctrl.sv
// External request flags, sense control, standby release and forwarding
// of the winning request to the CPU, with an AXI4-Lite register slave.
// Assumes a CPU that pulses exc_ack with the vector it is handling and a
// standby level from the power controller; one clock, synchronous reset.
`timescale 1ns/1ns
`include "ext_irq_defines.svh"

module ext_irq_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and system
  input wire logic [7:0] external_request_pin,
  input wire logic nmi_pin,
  input wire logic peri_req,
  input wire logic sw_standby,
  // CPU side
  input wire logic exc_ack,
  input wire logic [7:0] exc_vector,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic [2:0] irq_level,
  output logic nmi_req,
  output logic standby_wake
);

  // Settling time in cycles, rounded up
  localparam int SETTLE_CYC = (`SETTLE_NS * `CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic aw_got;                     // Write address held
    logic [7:0] awaddr;
    logic w_got;                      // Write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] flags;                // external_request_flags
    logic [7:0] read_seen;            // Flag read while one
    logic nmi_flag;
    logic [7:0] wake_en;              // standby_wake_pin_enable
    logic [15:0] sense;               // sense_control_register
    logic [7:0] pin_en;               // pin_request_enable_register
    logic nmi_rise;                   // nonmaskable_edge_select
    logic [1:0] mode;                 // Interrupt control mode
    logic peri_en;                    // Internal source enable
    logic [26:0] prio;                // priority_level_register
    ext_irq_pkg::wake_state_e wake_st;
    logic [`SETTLE_W-1:0] settle_cnt;
    logic wake;
    logic irq_req;
    logic [7:0] irq_vec;
    logic [2:0] irq_lvl;
    logic nmi_req;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Synchronised pin level and edges; bit 8 is the nonmaskable pin
  logic [8:0] pin_lvl;
  logic [8:0] pin_fall;
  logic [8:0] pin_rise;
  // Arbiter
  logic [`NUM_SRC-1:0] pend;
  logic win_valid;
  logic [3:0] win_idx;
  logic [2:0] win_lvl;

  // Vector of source index (index order follows vector order)
  function automatic logic [7:0] vector_of(input logic [3:0] idx);
    if (idx == 4'(`SRC_NMI)) begin
      vector_of = `VEC_NMI;
    end else if (idx == 4'(`SRC_PERI)) begin
      vector_of = `VEC_PERI;
    end else begin
      vector_of = `VEC_PIN0 + 8'(idx - 4'h1);
    end
  endfunction : vector_of

  // Detection event of one pin under its sense code
  function automatic logic sensed(input logic [1:0] code, input logic lvl,
      input logic fl, input logic rs);
    unique case (code)
      `SENSE_LOW: sensed = !lvl;
      `SENSE_FALL: sensed = fl;
      `SENSE_RISE: sensed = rs;
      `SENSE_BOTH: sensed = fl | rs;
    endcase
  endfunction : sensed

  // Byte-lane merge of a write into a register image, one strobe a byte
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_merge = (old & ~m) | (wd & m);
  endfunction : lane_merge

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  // Pins read whatever their direction setting
  pin_sync_detect u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({nmi_pin, external_request_pin}),
    .level(pin_lvl),
    .fall(pin_fall),
    .rise(pin_rise)
  );

  // Pending set: flags gated by enables
  assign pend = {st_r.peri_en & peri_req, st_r.flags & st_r.pin_en, st_r.nmi_flag};

  src_arbiter u_arb (
    .pend(pend),
    .levels(st_r.prio),
    .level_mode(st_r.mode == `MODE_PRIO),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] det;
    logic [7:0] set_ev;
    logic [7:0] clr;
    logic nmi_ev;
    det = '0;
    set_ev = '0;
    clr = '0;
    nmi_ev = 1'b0;
    st_nxt = st_r;

    // Per-pin detection, standby sampling gated by wake enable
    for (int i = 0; i < `NUM_PINS; i++) begin
      det[i] = sensed(st_r.sense[2*i +: 2], pin_lvl[i], pin_fall[i], pin_rise[i]);
      set_ev[i] = det[i] & (!sw_standby | st_r.wake_en[i]);
    end
    // Nonmaskable edge as selected
    nmi_ev = st_r.nmi_rise ? pin_rise[8] : pin_fall[8];

    // Write address and data, in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `RESP_OKAY;
      unique case (st_r.awaddr)
        `OFF_FLAGS: begin
          // Only zero written to a bit seen as one clears it
          if (st_r.wstrb[0]) begin
            clr = ~st_r.wdata[7:0] & st_r.read_seen;
          end
        end
        `OFF_WAKE_EN: st_nxt.wake_en = 8'(lane_merge(32'(st_r.wake_en), st_r.wdata, st_r.wstrb));
        `OFF_SENSE: st_nxt.sense = 16'(lane_merge(32'(st_r.sense), st_r.wdata, st_r.wstrb));
        `OFF_PIN_EN: st_nxt.pin_en = 8'(lane_merge(32'(st_r.pin_en), st_r.wdata, st_r.wstrb));
        `OFF_CTRL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.nmi_rise = st_r.wdata[`CTRL_NMI_EDGE];
            st_nxt.mode = st_r.wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
          end
          if (st_r.wstrb[1]) begin
            st_nxt.peri_en = st_r.wdata[`CTRL_PERI_EN];
          end
        end
        `OFF_PRIO: st_nxt.prio = 27'(lane_merge(32'(st_r.prio), st_r.wdata, st_r.wstrb));
        `OFF_STATUS: st_nxt.bresp = `RESP_OKAY; // Read-only, write ignored
        default: begin
          st_nxt.bresp = `RESP_SLVERR;
        end
      endcase
    end
    st_nxt.bvalid = st_nxt.bvalid & ~(st_r.bvalid & s_axi_bready); // Response taken

    // Read channel
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `RESP_OKAY;
      st_nxt.rdata = '0;
      unique case (s_axi_araddr)
        `OFF_FLAGS: begin
          st_nxt.rdata[7:0] = st_r.flags;
          // Arms the zero-write clear for bits read as one
          st_nxt.read_seen = st_r.read_seen | st_r.flags;
        end
        `OFF_WAKE_EN: st_nxt.rdata[7:0] = st_r.wake_en;
        `OFF_SENSE: st_nxt.rdata[15:0] = st_r.sense;
        `OFF_PIN_EN: st_nxt.rdata[7:0] = st_r.pin_en;
        `OFF_CTRL: begin
          st_nxt.rdata[`CTRL_NMI_EDGE] = st_r.nmi_rise;
          st_nxt.rdata[`CTRL_MODE_HI:`CTRL_MODE_LO] = st_r.mode;
          st_nxt.rdata[`CTRL_PERI_EN] = st_r.peri_en;
        end
        `OFF_PRIO: st_nxt.rdata[26:0] = st_r.prio;
        `OFF_STATUS: begin
          st_nxt.rdata[7:0] = st_r.irq_vec;
          st_nxt.rdata[`STAT_STANDBY] = sw_standby;
          st_nxt.rdata[`STAT_SETTLE] = (st_r.wake_st == ext_irq_pkg::WAKE_SETTLE);
        end
        default: begin
          st_nxt.rresp = `RESP_SLVERR;
        end
      endcase
    end
    st_nxt.rvalid = st_nxt.rvalid & ~(st_r.rvalid & s_axi_rready); // Answer taken

    // Exception handling clears the flag of the vector taken
    if (exc_ack) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        if (exc_vector == vector_of(4'(i + 1))) begin
          // Edge modes always low level once its source let go
          clr[i] = clr[i] | (st_r.sense[2*i +: 2] != `SENSE_LOW) | pin_lvl[i];
        end
      end
      if (exc_vector == `VEC_NMI) begin
        st_nxt.nmi_flag = 1'b0;
      end
    end
    if (nmi_ev) begin
      st_nxt.nmi_flag = 1'b1; // Set wins over clear
    end

    // Flags: a set in the clearing cycle wins
    st_nxt.flags = (st_r.flags & ~clr) | set_ev;
    st_nxt.read_seen = st_nxt.read_seen & st_nxt.flags & ~clr;

    // Standby release: any enabled pin or the nonmaskable pin
    st_nxt.wake = 1'b0;
    unique case (st_r.wake_st)
      ext_irq_pkg::WAKE_IDLE: begin
        if (sw_standby && (nmi_ev || |(det & st_r.wake_en))) begin
          st_nxt.wake_st = ext_irq_pkg::WAKE_SETTLE;
          st_nxt.settle_cnt = '0;
        end
      end
      ext_irq_pkg::WAKE_SETTLE: begin
        if (st_r.settle_cnt == `SETTLE_W'(SETTLE_CYC - 1)) begin
          st_nxt.wake = 1'b1;
          st_nxt.wake_st = ext_irq_pkg::WAKE_IDLE;
        end else begin
          st_nxt.settle_cnt = st_r.settle_cnt + `SETTLE_W'(1);
        end
      end
    endcase

    // Forward the winner to the CPU
    st_nxt.irq_req = win_valid;
    st_nxt.irq_vec = win_valid ? vector_of(win_idx) : 8'h00;
    st_nxt.irq_lvl = win_valid ? win_lvl : 3'h0;
    st_nxt.nmi_req = st_r.nmi_flag;

    // Ready flags follow the held state
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = !st_nxt.rvalid;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.flags <= `RST_FLAGS;
      st_r.wake_en <= `RST_WAKE_EN;
      st_r.sense <= `RST_SENSE;
      st_r.pin_en <= `RST_PIN_EN;
      st_r.prio <= `RST_PRIO;
      st_r.wake_st <= ext_irq_pkg::WAKE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign irq_req = st_r.irq_req;
  assign irq_vector = st_r.irq_vec;
  assign irq_vector_addr = {6'h00, st_r.irq_vec, 2'h0};
  assign irq_level = st_r.irq_lvl;
  assign nmi_req = st_r.nmi_req;
  assign standby_wake = st_r.wake;

endmodule : ext_irq_ctrl

// >>> rtl/ext_irq_defines.svh
// Register map, reset values, field positions, encodings and timing of the
// external request block.
// Assumes inclusion by bare name from every file that needs a constant.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_FLAGS 8'h00
`define OFF_WAKE_EN 8'h04
`define OFF_SENSE 8'h08
`define OFF_PIN_EN 8'h0C
`define OFF_CTRL 8'h10
`define OFF_PRIO 8'h14
`define OFF_STATUS 8'h18

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_FLAGS 8'h00
`define RST_WAKE_EN 8'h07
`define RST_SENSE 16'h0000
`define RST_PIN_EN 8'h00
`define RST_PRIO 27'h0000000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_NMI_EDGE 0
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5
`define CTRL_PERI_EN 8
`define LVL_W 3
`define STAT_SETTLE 9
`define STAT_STANDBY 8

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define SENSE_LOW 2'h0
`define SENSE_FALL 2'h1
`define SENSE_RISE 2'h2
`define SENSE_BOTH 2'h3
`define MODE_PRIO 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Vectors and sources
// ----------------------------------------------------------------------
`define VEC_NMI 8'h07
`define VEC_PIN0 8'h10
`define VEC_PERI 8'h21
`define NUM_PINS 8
`define NUM_SRC 10
`define SRC_NMI 0
`define SRC_PERI 9

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ 125
`define SETTLE_NS 10000
`define SETTLE_W 11

`endif

// >>> rtl/ext_irq_pkg.sv
// Types shared by the external request block.
// Assumes ext_irq_defines.svh supplies every number.
`include "ext_irq_defines.svh"

package ext_irq_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Standby release sequencing
  typedef enum logic [0:0] {WAKE_IDLE, WAKE_SETTLE} wake_state_e;

  // Per-source priority level
  typedef logic [`LVL_W-1:0] level_t;

  // Pin synchroniser state
  typedef struct packed {
    logic [8:0] meta;
    logic [8:0] sync;
    logic [8:0] prev;
  } sync_s;

endpackage : ext_irq_pkg

// >>> rtl/pin_sync_detect.sv
// Synchronises the nine request pins and finds their edges.
// Assumes one clock; pins are treated as asynchronous inputs.
`timescale 1ns/1ns
`include "ext_irq_defines.svh"

module pin_sync_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [8:0] pins,
  output logic [8:0] level,
  output logic [8:0] fall,
  output logic [8:0] rise
);

  // All state of this module
  ext_irq_pkg::sync_s st_r;
  ext_irq_pkg::sync_s st_nxt;

  // --------------------------------------------------------------------
  // Next state: two flops deep, then one more for edge history
  // --------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = pins;
    st_nxt.sync = st_r.meta; // First flop only feeds second
    st_nxt.prev = st_r.sync;
  end

  // Register the state; pins idle high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '{meta: 9'h1FF, sync: 9'h1FF, prev: 9'h1FF};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Clean single-cycle events from synchronised samples
  assign level = st_r.sync;
  assign fall = st_r.prev & ~st_r.sync;
  assign rise = ~st_r.prev & st_r.sync;

endmodule : pin_sync_detect

// >>> rtl/src_arbiter.sv
// Picks the pending source that wins under default or level priority.
// Assumes index order equals vector order, index 0 being nonmaskable.
`timescale 1ns/1ns
`include "ext_irq_defines.svh"

module src_arbiter (
  input wire logic [`NUM_SRC-1:0] pend,
  input wire logic [`LVL_W*(`NUM_SRC-1)-1:0] levels,
  input wire logic level_mode,
  output logic win_valid,
  output logic [3:0] win_idx,
  output logic [`LVL_W-1:0] win_lvl
);

  // Level of maskable source i (1..9)
  function automatic ext_irq_pkg::level_t lvl_of(input logic [3:0] i,
      input logic [`LVL_W*(`NUM_SRC-1)-1:0] lv);
    lvl_of = lv[(i - 4'h1) * `LVL_W +: `LVL_W];
  endfunction : lvl_of

  // ----------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------
  always_comb begin
    win_valid = 1'b0;
    win_idx = 4'h0;
    win_lvl = '0;
    if (pend[`SRC_NMI]) begin
      // Nonmaskable always first
      win_valid = 1'b1;
      win_lvl = '1;
    end else begin
      for (int i = 1; i < `NUM_SRC; i++) begin
        if (pend[i]) begin
          // Strict greater keeps the smaller vector on a tie
          if (!win_valid || (level_mode && lvl_of(4'(i), levels) > win_lvl)) begin
            win_valid = 1'b1;
            win_idx = 4'(i);
            win_lvl = lvl_of(4'(i), levels);
          end
        end
      end
    end
  end

endmodule : src_arbiter
